// ===== csg_top.sv
// Status signalling: enable sequencing, ready/fault flag, temperature PWM
`timescale 1ns/1ps
module csg_top #(
    parameter int READY_DELAY_CYC = csg_pkg::READY_DELAY_CYC
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic power_on_req,
    input wire logic power_on_req_driven,
    input wire logic pri_ready,
    input wire logic fault_detect,
    input wire logic mgmt_cmd_valid,
    input wire logic mgmt_on_cmd,
    input wire logic signed [7:0] temp_c,
    output logic bias_en,
    output logic power_stage_on,
    output logic ready_fault_flag,
    output logic temp_valid,
    output logic temp_pwm_out
);
    import csg_pkg::*;

    localparam int FLAG_DROP_MAX = FAULT_FLAG_DELAY_CYC;
    localparam logic [TIMER_W-1:0] START_LAST = TIMER_W'(START_DELAY_CYC - 1);
    localparam logic [TIMER_W-1:0] READY_LAST = TIMER_W'(READY_DELAY_CYC - 1);
    localparam logic [TIMER_W-1:0] TV_LAST = TIMER_W'(TEMP_VALID_CYC - 1);
    localparam logic [TIMER_W-1:0] AGE_MAX = '1;

    logic en_eff;
    logic go;
    logic mgmt_on_q;
    csg_state_t state_q, state_d;
    logic [TIMER_W-1:0] timer_q;
    logic [TIMER_W-1:0] stage_age_q;
    logic stage_on_d;
    logic [PWM_CNT_W-1:0] temp_duty_cycle_q;
    int mv_i;
    int hi_i;
    logic [PWM_CNT_W-1:0] duty_d;

    // Undriven request pin is pulled up, so it reads as on
    assign en_eff = power_on_req_driven ? power_on_req : 1'b1;
    assign go = en_eff && pri_ready && mgmt_on_q;

    // Management on/off, accepted only with request active
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            mgmt_on_q <= MGMT_ON_RST;
        end else if (mgmt_cmd_valid && en_eff) begin
            mgmt_on_q <= mgmt_on_cmd;
        end
    end

    // Next power sequencing state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            CSG_OFF: begin
                if (go) begin
                    state_d = CSG_START_WAIT;
                end
            end
            CSG_START_WAIT: begin
                if (fault_detect) begin
                    state_d = CSG_FAULT;
                end else if (!go) begin
                    state_d = CSG_OFF;
                end else if (timer_q == START_LAST) begin
                    state_d = CSG_SOFT_START;
                end
            end
            CSG_SOFT_START: begin
                if (fault_detect) begin
                    state_d = CSG_FAULT;
                end else if (!go) begin
                    state_d = CSG_OFF;
                end else if (timer_q == READY_LAST) begin
                    state_d = CSG_RUN;
                end
            end
            CSG_RUN: begin
                if (fault_detect) begin
                    state_d = CSG_FAULT;
                end else if (!go) begin
                    state_d = CSG_OFF;
                end
            end
            CSG_FAULT: begin
                if (!en_eff) begin
                    state_d = CSG_OFF;
                end
            end
            default: state_d = CSG_OFF;
        endcase
    end

    assign stage_on_d = (state_d == CSG_SOFT_START) || (state_d == CSG_RUN);

    // State register
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_q <= CSG_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // Delay timer, restarted on every state change
    always_ff @(posedge core_clk) begin
        if (!reset_n || state_d != state_q) begin
            timer_q <= '0;
        end else if (state_q == CSG_START_WAIT || state_q == CSG_SOFT_START) begin
            timer_q <= timer_q + 1'b1;
        end
    end

    // Cycles since the power stage came on, saturating
    always_ff @(posedge core_clk) begin
        if (!reset_n || !power_stage_on) begin
            stage_age_q <= '0;
        end else if (stage_age_q != AGE_MAX) begin
            stage_age_q <= stage_age_q + 1'b1;
        end
    end

    // Bias, power stage and flag outputs
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            bias_en <= 1'b0;
            power_stage_on <= 1'b0;
            ready_fault_flag <= 1'b0;
        end else begin
            bias_en <= en_eff;
            power_stage_on <= stage_on_d;
            ready_fault_flag <= (state_d == CSG_RUN);
        end
    end

    // Temperature output valid after settling
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            temp_valid <= 1'b0;
        end else begin
            temp_valid <= power_stage_on && stage_on_d && (stage_age_q >= TV_LAST);
        end
    end

    // Temperature to high-time in carrier cycles, rounded and clamped
    always_comb begin
        mv_i = TM_REF_MV + TM_GAIN_MV * (int'(temp_c) - TM_REF_DEGC);
        hi_i = (mv_i * PWM_PERIOD_CYC + TM_SUPPLY_MV / 2) / TM_SUPPLY_MV;
        if (hi_i < DUTY_MIN_CYC) begin
            hi_i = DUTY_MIN_CYC;
        end else if (hi_i > DUTY_MAX_CYC) begin
            hi_i = DUTY_MAX_CYC;
        end
        duty_d = PWM_CNT_W'(hi_i);
    end

    // Registered duty value
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            temp_duty_cycle_q <= PWM_CNT_W'(DUTY_MIN_CYC);
        end else begin
            temp_duty_cycle_q <= duty_d;
        end
    end

    // PWM carrier generator
    csg_pwm u_csg_pwm (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .run(temp_valid),
        .duty_cyc(temp_duty_cycle_q),
        .pwm_out(temp_pwm_out)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    property p_req_low_off;
        !en_eff |=> !bias_en && !power_stage_on;
    endproperty
    a_req_low_off: assert property (p_req_low_off) else $error("Stage active with request low");

    property p_undriven_starts;
        state_q == CSG_OFF && !power_on_req_driven && pri_ready && mgmt_on_q
            |=> state_q == CSG_START_WAIT;
    endproperty
    a_undriven_starts: assert property (p_undriven_starts) else $error("Undriven request not on");

    property p_start_delay;
        $rose(power_stage_on) |-> $past(timer_q) == START_LAST;
    endproperty
    a_start_delay: assert property (p_start_delay) else $error("Start delay wrong");

    property p_ready_delay;
        $rose(ready_fault_flag) |-> stage_age_q == TIMER_W'(READY_DELAY_CYC);
    endproperty
    a_ready_delay: assert property (p_ready_delay) else $error("Ready delay wrong");

    property p_temp_valid_delay;
        $rose(temp_valid) |-> stage_age_q == TIMER_W'(TEMP_VALID_CYC);
    endproperty
    a_temp_valid_delay: assert property (p_temp_valid_delay) else $error("Temp valid delay wrong");

    property p_fault_low;
        fault_detect |=> !ready_fault_flag;
    endproperty
    a_fault_low: assert property (p_fault_low) else $error("Flag high during fault");

    property p_fault_time;
        fault_detect |-> ##[1:FLAG_DROP_MAX] !ready_fault_flag;
    endproperty
    a_fault_time: assert property (p_fault_time) else $error("Flag drop too slow");

    property p_fault_latched;
        state_q == CSG_FAULT && en_eff |=> state_q == CSG_FAULT && !ready_fault_flag;
    endproperty
    a_fault_latched: assert property (p_fault_latched) else $error("Fault not latched");

    property p_mgmt_ignored;
        mgmt_cmd_valid && !en_eff |=> $stable(mgmt_on_q);
    endproperty
    a_mgmt_ignored: assert property (p_mgmt_ignored) else $error("Command taken with request low");

    property p_duty_ref;
        temp_c == 8'sh1B ##1 temp_c == 8'sh1B |-> temp_duty_cycle_q == PWM_CNT_W'(15);
    endproperty
    a_duty_ref: assert property (p_duty_ref) else $error("Duty wrong at reference temp");

    property p_duty_range;
        temp_duty_cycle_q >= PWM_CNT_W'(DUTY_MIN_CYC)
            && temp_duty_cycle_q <= PWM_CNT_W'(DUTY_MAX_CYC);
    endproperty
    a_duty_range: assert property (p_duty_range) else $error("Duty out of range");

    c_ready_rise: cover property ($rose(ready_fault_flag));
    c_fault_in_run: cover property (state_q == CSG_RUN ##1 state_q == CSG_FAULT);
    c_restart: cover property (state_q == CSG_FAULT ##1 state_q == CSG_OFF);
endmodule : csg_top

// ===== csg_pkg.sv
// Constants and types for the converter status signalling block
package csg_pkg;
    // Clock and time base
    localparam int CLK_HZ = 10_000_000;
    localparam int CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1_000;
    // Temperature PWM carrier
    localparam int PWM_HZ = 250_000;
    localparam int PWM_PERIOD_CYC = CLK_HZ / PWM_HZ;
    localparam int PWM_CNT_W = 6;
    // Temperature to voltage mapping, millivolts and degrees
    localparam int TM_REF_MV = 1270;
    localparam int TM_REF_DEGC = 27;
    localparam int TM_GAIN_MV = 10;
    localparam int TM_SUPPLY_MV = 3300;
    // Duty limits in hundredths of a percent
    localparam int DUTY_MIN_CP = 1818;
    localparam int DUTY_MAX_CP = 6818;
    localparam int DUTY_MIN_CYC = (DUTY_MIN_CP * PWM_PERIOD_CYC + 9999) / 10000;
    localparam int DUTY_MAX_CYC = (DUTY_MAX_CP * PWM_PERIOD_CYC) / 10000;
    // Start-up and fault timing
    localparam int START_DELAY_US = 250;
    localparam int START_DELAY_CYC = START_DELAY_US * CYC_PER_US;
    localparam int TEMP_VALID_US = 100;
    localparam int TEMP_VALID_CYC = TEMP_VALID_US * CYC_PER_US;
    localparam int READY_DELAY_MS = 2;
    localparam int READY_DELAY_CYC = READY_DELAY_MS * CYC_PER_MS;
    localparam int FAULT_FLAG_DELAY_US = 10;
    localparam int FAULT_FLAG_DELAY_CYC = FAULT_FLAG_DELAY_US * CYC_PER_US;
    localparam int TIMER_W = 16;
    // Reset values
    localparam logic MGMT_ON_RST = 1'b1;
    // Power sequencing states
    typedef enum logic [2:0] {
        CSG_OFF,
        CSG_START_WAIT,
        CSG_SOFT_START,
        CSG_RUN,
        CSG_FAULT
    } csg_state_t;
endpackage : csg_pkg

// ===== csg_pwm.sv
// Fixed-carrier PWM generator for the temperature output
`timescale 1ns/1ps
module csg_pwm (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic run,
    input wire logic [csg_pkg::PWM_CNT_W-1:0] duty_cyc,
    output logic pwm_out
);
    import csg_pkg::*;

    localparam logic [PWM_CNT_W-1:0] PWM_LAST = PWM_CNT_W'(PWM_PERIOD_CYC - 1);

    logic [PWM_CNT_W-1:0] cnt_q;
    logic [PWM_CNT_W-1:0] duty_lat_q;

    // Period counter, held at zero while idle
    always_ff @(posedge core_clk) begin
        if (!reset_n || !run || cnt_q == PWM_LAST) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Duty latched at a period boundary, and every cycle while idle
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            duty_lat_q <= '0;
        end else if (!run || cnt_q == PWM_LAST) begin
            duty_lat_q <= duty_cyc;
        end
    end

    // High for the duty part, high when idle
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pwm_out <= 1'b1;
        end else begin
            pwm_out <= !run || (cnt_q < duty_lat_q);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    property p_pwm_idle_high;
        !run |=> pwm_out;
    endproperty
    a_pwm_idle_high: assert property (p_pwm_idle_high) else $error("PWM not high when idle");

    property p_pwm_period;
        run && cnt_q == PWM_LAST ##1 run |-> cnt_q == '0;
    endproperty
    a_pwm_period: assert property (p_pwm_period) else $error("PWM period length wrong");

    property p_duty_at_boundary;
        $changed(duty_lat_q) |-> cnt_q == '0;
    endproperty
    a_duty_at_boundary: assert property (p_duty_at_boundary) else $error("Duty changed mid period");

    c_pwm_low_phase: cover property (run ##1 !pwm_out);
endmodule : csg_pwm

// ===== csg_host_model.sv
// Host controller model driving the request side of the status block
`timescale 1ns/1ps
module csg_host_model (
    input wire logic want_on,
    input wire logic let_float,
    input wire logic supply_ok,
    output logic power_on_req,
    output logic power_on_req_driven,
    output logic pri_ready
);
    // Released request pin settles at the pull-up level
    // Driven request follows want_on, and power_on_req_driven is low while released
    assign power_on_req = let_float ? 1'b1 : want_on;
    assign power_on_req_driven = ~let_float;
    // Primary supply qualified
    assign pri_ready = supply_ok;
endmodule : csg_host_model

// ===== csg_top_tb_top.sv
// Self-checking testbench for the status signalling block
`timescale 1ns/1ps
module csg_top_tb_top;
    import csg_pkg::*;
    localparam int RDY = 50;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic want_on = 1'b1;
    logic let_float = 1'b0;
    logic supply_ok = 1'b0;
    logic fault_detect = 1'b0;
    logic mgmt_cmd_valid = 1'b0;
    logic mgmt_on_cmd = 1'b1;
    logic signed [7:0] temp_c = 8'sh1B;
    logic power_on_req, power_on_req_driven, pri_ready;
    logic bias_en, power_stage_on, ready_fault_flag, temp_valid, temp_pwm_out;
    logic [3:0] last_v = 4'h0;
    logic [3:0] exp_q[$];
    int when_q[$];
    int duty_q[$];
    logic probe = 1'b0;
    logic armed = 1'b0;
    int failures = 0;
    int samples_checked = 0;
    int cyc = 0;
    int t0 = 0;
    int hi = 0;
    int lo = 0;
    int w;
    int temps[6];

    csg_host_model u_csg_host_model (.want_on(want_on), .let_float(let_float),
        .supply_ok(supply_ok), .power_on_req(power_on_req),
        .power_on_req_driven(power_on_req_driven), .pri_ready(pri_ready));

    csg_top #(.READY_DELAY_CYC(RDY)) u_csg_top (.core_clk(core_clk), .reset_n(reset_n),
        .power_on_req(power_on_req), .power_on_req_driven(power_on_req_driven),
        .pri_ready(pri_ready), .fault_detect(fault_detect), .mgmt_cmd_valid(mgmt_cmd_valid),
        .mgmt_on_cmd(mgmt_on_cmd), .temp_c(temp_c), .bias_en(bias_en),
        .power_stage_on(power_stage_on), .ready_fault_flag(ready_fault_flag),
        .temp_valid(temp_valid), .temp_pwm_out(temp_pwm_out));

    // Clock and edge counter
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            failures++;
            $display("BAD t=%0t seen=%0h want=%0h", $time, seen, want);
        end
    endtask : chk

    task automatic print_verdict;
        if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        t0 = cyc;
    endtask : tick

    task automatic note(input logic [3:0] v, input int dt);
        exp_q.push_back(v);
        when_q.push_back(dt == 0 ? 0 : t0 + dt);
    endtask : note

    // Full start from a qualified request: stage, ready, temperature
    task automatic expect_start;
        note(4'hC, 2502);
        note(4'hE, 2502 + RDY);
        note(4'hF, 3502);
        tick(3400);
        #1 chk(temp_pwm_out, 1'b1);
        tick(200);
    endtask : expect_start

    task automatic mgmt(input logic on);
        mgmt_cmd_valid <= 1'b1;
        mgmt_on_cmd <= on;
        tick(1);
        mgmt_cmd_valid <= 1'b0;
    endtask : mgmt

    function automatic int exp_duty(input int t);
        int d;
        d = ((TM_REF_MV + TM_GAIN_MV * (t - TM_REF_DEGC)) * PWM_PERIOD_CYC
            + TM_SUPPLY_MV / 2) / TM_SUPPLY_MV;
        return d < DUTY_MIN_CYC ? DUTY_MIN_CYC : (d > DUTY_MAX_CYC ? DUTY_MAX_CYC : d);
    endfunction : exp_duty

    // Status outputs: each change is matched with the oldest note
    always @(negedge core_clk) begin
        if (reset_n && {bias_en, power_stage_on, ready_fault_flag, temp_valid} !== last_v) begin
            last_v = {bias_en, power_stage_on, ready_fault_flag, temp_valid};
            if (exp_q.size() == 0) chk(last_v, ~last_v);
            else begin
                chk(last_v, exp_q.pop_front());
                w = when_q.pop_front();
                if (w != 0) chk(cyc, w);
            end
        end
    end

    // PWM: one full high run and the low run after it
    always @(negedge core_clk) begin
        if (!probe) armed = 1'b0;
        else if (!armed) begin
            armed = !temp_pwm_out;
            hi = 0;
            lo = 0;
        end else if (temp_pwm_out && lo > 0) begin
            chk(hi, duty_q.pop_front());
            chk(hi + lo, PWM_PERIOD_CYC);
            probe = 1'b0;
        end else if (temp_pwm_out) hi++;
        else if (hi > 0) lo++;
    end

    // Watchdog
    initial begin
        repeat (60000) @(posedge core_clk);
        failures++;
        print_verdict();
    end

    initial begin
        void'($urandom(52));
        temps = '{-40, 125, 27, 0, 0, 0};
        for (int i = 3; i < 6; i++) temps[i] = int'($urandom_range(165)) - 40;
        tick(6);
        reset_n <= 1'b1;
        note(4'h8, 2);
        #1 chk({bias_en, power_stage_on, ready_fault_flag, temp_valid, temp_pwm_out}, 5'h01);
        tick(3000);
        supply_ok <= 1'b1;
        expect_start();
        // Temperature sweep including both clamp ends
        for (int i = 0; i < 6; i++) begin
            temp_c <= temps[i][7:0];
            duty_q.push_back(exp_duty(temps[i]));
            tick(100);
            probe <= 1'b1;
            tick(1);
            for (int k = 0; k < 200 && probe; k++) tick(1);
            chk(probe, 1'b0);
        end
        // Management off then on while running
        mgmt(1'b0);
        note(4'h8, 0);
        tick(50);
        mgmt(1'b1);
        note(4'hC, 0);
        note(4'hE, 0);
        note(4'hF, 0);
        tick(3700);
        // Fault latches the flag low until the request cycles
        fault_detect <= 1'b1;
        note(4'h8, 2);
        tick(6);
        fault_detect <= 1'b0;
        tick(200);
        want_on <= 1'b0;
        note(4'h0, 2);
        tick(11);
        mgmt(1'b0);
        tick(20);
        let_float <= 1'b1;
        note(4'h8, 2);
        expect_start();
        chk(exp_q.size(), 0);
        print_verdict();
    end
endmodule : csg_top_tb_top
